// File: verilog/timer_pkg.sv
// Package of register map, field positions and constants for the timer
package timer_pkg;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 8;
  // Register offsets (byte addresses)
  localparam logic [7:0] MODULE_CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] INT_ENABLE_OFF = 8'h08;
  localparam logic [7:0] SW_RESET_OFF = 8'h0c;
  localparam logic [7:0] CH_BASE_OFF = 8'h20;
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [3:0] CH_LOAD_SUB = 4'h0;
  localparam logic [3:0] CH_COUNT_SUB = 4'h4;
  localparam logic [3:0] CH_CTRL_SUB = 4'h8;
  // Module control fields
  localparam int MC_ENABLE_BIT = 0;
  localparam int MC_DEBUG_BIT = 1;
  localparam int MC_DOZE_BIT = 2;
  // Channel control fields
  localparam int CC_ENABLE_BIT = 0;
  localparam int CC_CHAIN_BIT = 1;
  localparam int CC_SPLIT_BIT = 2;
  localparam int CC_SRC_BIT = 3;
  localparam int CC_RELOAD_BIT = 4;
  localparam int CC_STOP_BIT = 5;
  localparam int CC_START_BIT = 6;
  localparam int CC_SEL_LSB = 8;
  localparam int CC_SEL_W = 4;
  localparam int CC_W = 12;
  // Reset values
  localparam logic [31:0] LOAD_RESET = 32'h0000_0000;
  localparam logic [CC_W-1:0] CC_RESET = 12'h000;
  localparam logic [2:0] MC_RESET = 3'h0;
endpackage

// File: verilog/trig_edge.sv
// Rising edge detector for the external trigger inputs
`timescale 1ns/1ps
module trig_edge (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Level in, pulse out
  input wire logic [timer_pkg::NUM_CH-1:0] level_i,
  output logic [timer_pkg::NUM_CH-1:0] pulse_o
);
  typedef struct packed {
    logic [timer_pkg::NUM_CH-1:0] last;
    logic [timer_pkg::NUM_CH-1:0] pulse;
  } edge_state_t;
  edge_state_t st_reg, st_next;

  // Compare with the previous sample
  always_comb begin
    st_next = st_reg;
    st_next.pulse = level_i & ~st_reg.last;
    st_next.last = level_i;
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pulse_o = st_reg.pulse;
endmodule

// File: verilog/count_chan.sv
// One countdown channel: load, decrement, split halves and timeout
`timescale 1ns/1ps
module count_chan (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic run_i,
  input wire logic enable_i,
  input wire logic split_i,
  input wire logic reload_on_trigger_i,
  input wire logic stop_on_timeout_i,
  input wire logic start_on_trigger_i,
  input wire logic chain_to_lower_channel_i,
  input wire logic lower_tick_i,
  input wire logic trig_i,
  input wire logic [31:0] load_i,
  // Status
  output logic [31:0] count_o,
  output logic timeout_o,
  output logic pre_trig_o
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_RUN = 4'b0100,
    ST_DONE = 4'b1000
  } chan_state_t;
  typedef struct packed {
    chan_state_t fsm;
    logic [31:0] count;
    logic timeout;
    logic pre_trig;
  } chan_t;
  chan_t s_reg, s_next;
  logic step;

  // Chained channels only step when the lower one expires
  assign step = run_i && (chain_to_lower_channel_i ? lower_tick_i : 1'b1);

  always_comb begin
    s_next = s_reg;
    s_next.timeout = 1'b0;
    unique case (s_reg.fsm)
      ST_IDLE: begin
        s_next.pre_trig = 1'b0;
        if (enable_i) begin
          s_next.count = load_i;
          s_next.fsm = start_on_trigger_i ? ST_WAIT : ST_RUN;
        end
      end
      ST_WAIT: begin
        if (!enable_i) begin
          s_next.fsm = ST_IDLE;
        end else if (trig_i) begin
          s_next.count = load_i;
          s_next.fsm = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!enable_i) begin
          s_next.fsm = ST_IDLE;
        end else if (trig_i && reload_on_trigger_i) begin
          s_next.count = load_i;
          s_next.pre_trig = 1'b0;
        end else if (step) begin
          if (split_i && s_reg.count[15:0] != 16'h0000) begin
            s_next.count[15:0] = s_reg.count[15:0] - 16'h0001;
            // Lower half exhausted raises the pre-trigger
            if (s_reg.count[15:0] == 16'h0001) begin
              s_next.pre_trig = 1'b1;
            end
          end else if (split_i) begin
            s_next.count[31:16] = s_reg.count[31:16] - 16'h0001;
            if (s_reg.count[31:16] == 16'h0000) begin
              s_next.pre_trig = 1'b0;
              s_next.timeout = 1'b1;
              s_next.count = load_i;
              if (stop_on_timeout_i) begin
                s_next.fsm = ST_DONE;
              end
            end
          end else if (s_reg.count == 32'h0000_0000) begin
            // Pick up the latest period at expiry
            s_next.timeout = 1'b1;
            s_next.count = load_i;
            if (stop_on_timeout_i) begin
              s_next.fsm = ST_DONE;
            end
          end else begin
            s_next.count = s_reg.count - 32'h0000_0001;
          end
        end
      end
      ST_DONE: begin
        // Idle would reload at once; hold until the enable drops
        if (!enable_i) begin
          s_next.fsm = ST_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '{fsm: ST_IDLE, count: 32'h0000_0000, timeout: 1'b0,
                 pre_trig: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign count_o = s_reg.count;
  assign timeout_o = s_reg.timeout;
  assign pre_trig_o = s_reg.pre_trig;

  a_timeout_reload: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    timeout_o |-> count_o == $past(load_i))
    else $error("timeout without reload");
  a_pretrig_drop: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    $fell(pre_trig_o) && split_i && enable_i && !$past(trig_i)
    |-> timeout_o)
    else $error("pre-trigger fell without timeout");
endmodule

// File: verilog/countdown_timer.sv
// Top of the multi-channel periodic countdown timer with register port
`timescale 1ns/1ps
module countdown_timer (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [timer_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // System state
  input wire logic debug_i,
  input wire logic doze_i,
  // Triggers
  input wire logic [timer_pkg::NUM_CH-1:0] ext_trig_i,
  output logic [timer_pkg::NUM_CH-1:0] trig_pulse_o,
  output logic [timer_pkg::NUM_CH-1:0] pre_trig_o,
  // Interrupt
  output logic irq_o
);
  localparam int N = timer_pkg::NUM_CH;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0] mctrl;
    logic [N-1:0] status;
    logic [N-1:0] int_en;
    logic [N-1:0][31:0] load;
    logic [N-1:0][timer_pkg::CC_W-1:0] cctrl;
    logic [31:0] rdata;
    logic [N-1:0] trig;
    logic [N-1:0] pre;
    logic irq;
    logic soft_rst;
  } top_t;
  top_t r_reg, r_next;

  logic [N-1:0][31:0] count;
  logic [N-1:0] tout;
  logic [N-1:0] pre;
  logic [N-1:0] ext_pulse;
  logic [N-1:0] trig_in;
  logic run;
  logic chan_rst_n;

  // Channel index of a channel register address, or N when not one
  function automatic int chan_of(input logic [timer_pkg::ADDR_W-1:0] a);
    int c;
    c = N;
    for (int i = 0; i < N; i++) begin
      if (a[7:4] == 4'(i + 2)) begin
        c = i;
      end
    end
    return c;
  endfunction

  // Gate counting on module enable and on debug and doze
  assign run = r_reg.mctrl[timer_pkg::MC_ENABLE_BIT] &&
               (!debug_i || r_reg.mctrl[timer_pkg::MC_DEBUG_BIT]) &&
               (!doze_i || r_reg.mctrl[timer_pkg::MC_DOZE_BIT]);

  // Channels share the soft reset pulse; held one cycle only
  assign chan_rst_n = rst_n_i && !r_reg.soft_rst;

  // ****************************************
  // Channels
  // ****************************************
  trig_edge u_edge (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .level_i(ext_trig_i),
    .pulse_o(ext_pulse)
  );

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_ch
      logic [timer_pkg::CC_SEL_W-1:0] sel;
      assign sel = r_reg.cctrl[g][timer_pkg::CC_SEL_LSB +:
                                  timer_pkg::CC_SEL_W];
      // Trigger picks external input or any channel's pulse, its own included
      assign trig_in[g] = r_reg.cctrl[g][timer_pkg::CC_SRC_BIT] ?
                          tout[sel[1:0]] : ext_pulse[sel[1:0]];
      count_chan u_ch (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(chan_rst_n),
        .run_i(run),
        .enable_i(r_reg.cctrl[g][timer_pkg::CC_ENABLE_BIT]),
        .split_i(r_reg.cctrl[g][timer_pkg::CC_SPLIT_BIT]),
        .reload_on_trigger_i(r_reg.cctrl[g][timer_pkg::CC_RELOAD_BIT]),
        .stop_on_timeout_i(r_reg.cctrl[g][timer_pkg::CC_STOP_BIT]),
        .start_on_trigger_i(r_reg.cctrl[g][timer_pkg::CC_START_BIT]),
        .chain_to_lower_channel_i(
          (g > 0) && r_reg.cctrl[g][timer_pkg::CC_CHAIN_BIT]),
        .lower_tick_i(tout[(g + N - 1) % N]),
        .trig_i(trig_in[g]),
        .load_i(r_reg.load[g]),
        .count_o(count[g]),
        .timeout_o(tout[g]),
        .pre_trig_o(pre[g])
      );
    end
  endgenerate

  // ****************************************
  // Register port and flags
  // ****************************************
  always_comb begin
    int c;
    c = chan_of(addr_i);
    r_next = r_reg;
    r_next.soft_rst = 1'b0;
    r_next.rdata = 32'h0000_0000;
    if (wr_i) begin
      if (addr_i == timer_pkg::MODULE_CTRL_OFF) begin
        r_next.mctrl = wdata_i[2:0];
      end else if (addr_i == timer_pkg::STATUS_OFF) begin
        r_next.status = r_reg.status & ~wdata_i[N-1:0];
      end else if (addr_i == timer_pkg::INT_ENABLE_OFF) begin
        r_next.int_en = wdata_i[N-1:0];
      end else if (addr_i == timer_pkg::SW_RESET_OFF) begin
        r_next.soft_rst = wdata_i[0];
      end else if (c < N && addr_i[3:0] == timer_pkg::CH_LOAD_SUB) begin
        r_next.load[c] = wdata_i; // Takes effect at next reload
      end else if (c < N && addr_i[3:0] == timer_pkg::CH_CTRL_SUB) begin
        r_next.cctrl[c] = wdata_i[timer_pkg::CC_W-1:0];
      end
    end
    if (rd_i) begin
      if (addr_i == timer_pkg::MODULE_CTRL_OFF) begin
        r_next.rdata = {29'h0000_0000, r_reg.mctrl};
      end else if (addr_i == timer_pkg::STATUS_OFF) begin
        r_next.rdata[N-1:0] = r_reg.status;
      end else if (addr_i == timer_pkg::INT_ENABLE_OFF) begin
        r_next.rdata[N-1:0] = r_reg.int_en;
      end else if (c < N && addr_i[3:0] == timer_pkg::CH_LOAD_SUB) begin
        r_next.rdata = r_reg.load[c];
      end else if (c < N && addr_i[3:0] == timer_pkg::CH_COUNT_SUB) begin
        r_next.rdata = count[c]; // Live counter
      end else if (c < N && addr_i[3:0] == timer_pkg::CH_CTRL_SUB) begin
        r_next.rdata[timer_pkg::CC_W-1:0] = r_reg.cctrl[c];
      end
    end
    // Set wins over a same-cycle clear
    r_next.status = r_next.status | tout;
    r_next.trig = tout; // One-cycle trigger pulse
    r_next.pre = pre;
    if (r_reg.soft_rst) begin
      // Everything but module control and read data returns to reset
      r_next.status = '0;
      r_next.int_en = '0;
      r_next.load = {N{timer_pkg::LOAD_RESET}};
      r_next.cctrl = {N{timer_pkg::CC_RESET}};
      r_next.trig = '0;
      r_next.pre = '0;
    end
    r_next.irq = |(r_next.status & r_next.int_en);
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rdata_o = r_reg.rdata;
  assign trig_pulse_o = r_reg.trig;
  assign pre_trig_o = r_reg.pre;
  assign irq_o = r_reg.irq;

  // ****************************************
  // Checks
  // ****************************************
  a_irq_level: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    irq_o == |(r_reg.status & r_reg.int_en))
    else $error("interrupt not matching flags");
  a_flag_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tout[0] && !r_reg.soft_rst |=> r_reg.status[0] && trig_pulse_o[0])
    else $error("timeout did not set flag");
  a_w1c_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == timer_pkg::STATUS_OFF && !wdata_i[0] &&
    r_reg.status[0] && !r_reg.soft_rst |=> r_reg.status[0])
    else $error("zero write cleared flag");
  a_w1c_one: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == timer_pkg::STATUS_OFF && wdata_i[0] && !tout[0]
    |=> !r_reg.status[0])
    else $error("one write did not clear flag");
  a_soft_keep: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    r_reg.soft_rst |=> r_reg.mctrl == $past(r_reg.mctrl) &&
    r_reg.int_en == '0)
    else $error("soft reset wrong");
  a_debug_halt: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    debug_i && !r_reg.mctrl[timer_pkg::MC_DEBUG_BIT] |-> !run)
    else $error("running in debug");
  a_doze_halt: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    doze_i && !r_reg.mctrl[timer_pkg::MC_DOZE_BIT] |-> !run)
    else $error("running in doze");
  a_count_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == 8'h24 |=> rdata_o == $past(count[0]))
    else $error("count read wrong");

  // Trigger pulse is the channel timeout, one clock later
  a_trig_follow: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    !r_reg.soft_rst |=> trig_pulse_o == $past(tout))
    else $error("trigger pulse not following timeout");

  // Pre-trigger output mirrors the channel level one clock later
  a_pre_follow: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    !r_reg.soft_rst |=> pre_trig_o == $past(pre))
    else $error("pre-trigger not following channel");

  // Read data stand only in the cycle after a read strobe
  a_rdata_idle: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    !rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data outside read cycle");

  // A period write lands in the register, not in the running count
  a_load_write: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    wr_i && !r_reg.soft_rst &&
    addr_i == (timer_pkg::CH_BASE_OFF | {4'h0, timer_pkg::CH_LOAD_SUB})
    |=> r_reg.load[0] == $past(wdata_i))
    else $error("period write lost");

  // Soft reset clears flags, periods and channel controls
  a_soft_clear: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    r_reg.soft_rst |=> r_reg.status == '0 && r_reg.cctrl == '0 &&
    r_reg.load == '0)
    else $error("soft reset left state behind");

  // Nothing counts while the module is disabled
  a_idle_halt: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    !r_reg.mctrl[timer_pkg::MC_ENABLE_BIT] |-> !run)
    else $error("counting while module disabled");

  // Module control takes the written run options
  a_mctrl_write: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    wr_i && addr_i == timer_pkg::MODULE_CTRL_OFF
    |=> r_reg.mctrl == $past(wdata_i[2:0]))
    else $error("module control write lost");

  // Interrupt enables take the written mask
  a_ien_write: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    wr_i && addr_i == timer_pkg::INT_ENABLE_OFF && !r_reg.soft_rst
    |=> r_reg.int_en == $past(wdata_i[N-1:0]))
    else $error("interrupt enable write lost");

  // A flag stays set until software writes the status register or a soft reset clears it
  a_flag_sticky: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    r_reg.status[0] && !r_reg.soft_rst &&
    !(wr_i && addr_i == timer_pkg::STATUS_OFF)
    |=> r_reg.status[0])
    else $error("flag dropped by itself");

  // Internal source with channel 0 selected follows its timeout
  a_int_source: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    r_reg.cctrl[2][timer_pkg::CC_SRC_BIT] &&
    r_reg.cctrl[2][timer_pkg::CC_SEL_LSB +: 2] == 2'h0
    |-> trig_in[2] == tout[0])
    else $error("internal trigger source wrong");
endmodule

// File: tb/countdown_timer_tb_top.sv
// Self-checking testbench for the multi-channel countdown timer
`timescale 1ns/1ps
module countdown_timer_tb_top;
  // ************************************************************
  // Signals and bench state
  // ************************************************************
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [timer_pkg::ADDR_W-1:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic debug_i = 1'b0;
  logic doze_i = 1'b0;
  logic [timer_pkg::NUM_CH-1:0] ext_trig_i = 4'h0;
  logic [timer_pkg::NUM_CH-1:0] trig_pulse_o;
  logic [timer_pkg::NUM_CH-1:0] pre_trig_o;
  logic irq_o;
  int miscompares = 0;
  int checks = 0;
  int n;
  int c;
  logic [31:0] v;
  logic [31:0] w;
  logic seen;
  // Control bits and register offsets, built from the package positions
  localparam logic [31:0] c_en = 32'h1 << timer_pkg::CC_ENABLE_BIT;
  localparam logic [31:0] c_chain = 32'h1 << timer_pkg::CC_CHAIN_BIT;
  localparam logic [31:0] c_split = 32'h1 << timer_pkg::CC_SPLIT_BIT;
  localparam logic [31:0] c_src = 32'h1 << timer_pkg::CC_SRC_BIT;
  localparam logic [31:0] c_rel = 32'h1 << timer_pkg::CC_RELOAD_BIT;
  localparam logic [31:0] c_stop = 32'h1 << timer_pkg::CC_STOP_BIT;
  localparam logic [31:0] c_start = 32'h1 << timer_pkg::CC_START_BIT;
  localparam logic [31:0] m_en = 32'h1 << timer_pkg::MC_ENABLE_BIT;
  localparam logic [7:0] mcr = timer_pkg::MODULE_CTRL_OFF;
  localparam logic [7:0] sts = timer_pkg::STATUS_OFF;
  localparam logic [7:0] ien = timer_pkg::INT_ENABLE_OFF;

  countdown_timer countdown_timer_i (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .debug_i(debug_i),
    .doze_i(doze_i),
    .ext_trig_i(ext_trig_i),
    .trig_pulse_o(trig_pulse_o),
    .pre_trig_o(pre_trig_o),
    .irq_o(irq_o)
  );

  // 250 MHz clock
  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // ************************************************************
  // Access and checking tasks
  // ************************************************************
  function automatic logic [7:0] ca(input int ch, input logic [3:0] sub);
    return timer_pkg::CH_BASE_OFF + timer_pkg::CH_STRIDE * 8'(ch) + {4'h0, sub};
  endfunction

  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write; the strobe drops at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // Counts edges until a channel pulses, bounded so a dead timer ends it
  task automatic wait_pulse(input int ch, input int lim, output logic hit,
                            output int cyc);
    hit = 1'b0;
    cyc = 0;
    while (!hit && cyc < lim) begin
      @(posedge sys_clk_i);
      #1;
      cyc++;
      hit = (trig_pulse_o[ch] === 1'b1);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: the tests need a few thousand cycles at most
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    // Reset values and an unmapped address all read zero
    rd(mcr, v);
    chk("module ctrl", v, 32'h0);
    rd(ien, v);
    chk("int enable", v, 32'h0);
    rd(ca(0, timer_pkg::CH_CTRL_SUB), v);
    chk("ch ctrl", v, 32'h0);
    rd(8'hfc, v);
    chk("unmapped", v, 32'h0);
    @(posedge sys_clk_i);
    #1;
    chk("idle rdata", rdata_o, 32'h0);
    $display("test reset done");
    // Periodic channel 0 with period 10; settle after module enable
    wr(mcr, m_en);
    repeat (5) @(posedge sys_clk_i);
    wr(ca(0, timer_pkg::CH_LOAD_SUB), 32'd10);
    wr(ca(0, timer_pkg::CH_CTRL_SUB), c_en);
    wait_pulse(0, 40, seen, n);
    chk("ch0 first pulse", 32'(seen), 32'h1);
    wait_pulse(0, 40, seen, n);
    chk("ch0 period", 32'(n), 32'd11);
    @(posedge sys_clk_i);
    #1;
    chk("pulse width", 32'(trig_pulse_o[0]), 32'h0);
    rd(ca(0, timer_pkg::CH_COUNT_SUB), v);
    chk("count range", 32'(v <= 32'd10), 32'h1);
    rd(sts, v);
    chk("ch0 flag", 32'(v[0]), 32'h1);
    // A new period must not restart the running countdown
    wr(ca(0, timer_pkg::CH_LOAD_SUB), 32'd20);
    wait_pulse(0, 40, seen, n);
    chk("old period kept", 32'(n <= 11), 32'h1);
    wait_pulse(0, 40, seen, n);
    chk("new period", 32'(n), 32'd21);
    wr(ca(0, timer_pkg::CH_CTRL_SUB), 32'h0);
    $display("test periodic done");
    // Interrupt follows flag and enable; write one clears the flag
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("irq masked", 32'(irq_o), 32'h0);
    wr(ien, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("irq raised", 32'(irq_o), 32'h1);
    wr(sts, 32'h0);
    rd(sts, v);
    chk("flag kept", 32'(v[0]), 32'h1);
    wr(sts, 32'h1);
    rd(sts, v);
    chk("flag cleared", 32'(v[0]), 32'h0);
    chk("irq dropped", 32'(irq_o), 32'h0);
    $display("test interrupt done");
    // Stop on timeout: one pulse, then silence
    wr(ca(1, timer_pkg::CH_LOAD_SUB), 32'd5);
    wr(ca(1, timer_pkg::CH_CTRL_SUB), c_en | c_stop);
    wait_pulse(1, 20, seen, n);
    chk("stop ch first", 32'(seen), 32'h1);
    wait_pulse(1, 40, seen, n);
    chk("stop ch silent", 32'(seen), 32'h0);
    $display("test stop done");
    // Split halves: lower 4 raises pre-trigger, upper 3 ends it
    wr(ca(2, timer_pkg::CH_LOAD_SUB), 32'h0003_0004);
    wr(ca(2, timer_pkg::CH_CTRL_SUB), c_en | c_split);
    n = 0;
    while (pre_trig_o[2] !== 1'b1 && n < 30) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk("pre trig up", 32'(pre_trig_o[2]), 32'h1);
    wait_pulse(2, 30, seen, n);
    chk("split timeout", 32'(seen), 32'h1);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("pre trig down", 32'(pre_trig_o[2]), 32'h0);
    rd(sts, v);
    chk("split flag", 32'(v[2]), 32'h1);
    wr(ca(2, timer_pkg::CH_CTRL_SUB), 32'h0);
    $display("test split done");
    // Chain: channel 1 steps once per channel 0 timeout
    wr(ca(1, timer_pkg::CH_CTRL_SUB), 32'h0);
    wr(ca(1, timer_pkg::CH_LOAD_SUB), 32'd2);
    wr(ca(1, timer_pkg::CH_CTRL_SUB), c_en | c_chain);
    wr(ca(0, timer_pkg::CH_LOAD_SUB), 32'd3);
    wr(ca(0, timer_pkg::CH_CTRL_SUB), c_en);
    w = 32'h0;
    n = 0;
    while (trig_pulse_o[1] !== 1'b1 && n < 60) begin
      @(posedge sys_clk_i);
      #1;
      n++;
      if (trig_pulse_o[0] === 1'b1) begin
        w++;
      end
    end
    chk("chain steps", w, 32'd3);
    wr(ca(1, timer_pkg::CH_CTRL_SUB), 32'h0);
    wr(ca(0, timer_pkg::CH_LOAD_SUB), 32'd100);
    $display("test chain done");
    // Debug (c=0) and doze (c=1) halt unless their run option is set
    for (c = 0; c < 2; c++) begin
      @(posedge sys_clk_i);
      debug_i <= (c == 0);
      doze_i <= (c == 1);
      repeat (3) @(posedge sys_clk_i);
      rd(ca(0, timer_pkg::CH_COUNT_SUB), v);
      repeat (10) @(posedge sys_clk_i);
      rd(ca(0, timer_pkg::CH_COUNT_SUB), w);
      chk("halted count", w, v);
      wr(mcr, m_en | (32'h1 << (c == 0 ? timer_pkg::MC_DEBUG_BIT :
                                timer_pkg::MC_DOZE_BIT)));
      repeat (5) @(posedge sys_clk_i);
      rd(ca(0, timer_pkg::CH_COUNT_SUB), v);
      repeat (10) @(posedge sys_clk_i);
      rd(ca(0, timer_pkg::CH_COUNT_SUB), w);
      chk("running count", 32'(v !== w), 32'h1);
      @(posedge sys_clk_i);
      debug_i <= 1'b0;
      doze_i <= 1'b0;
      wr(mcr, m_en);
      repeat (5) @(posedge sys_clk_i);
    end
    wr(ca(0, timer_pkg::CH_CTRL_SUB), 32'h0);
    $display("test debug doze done");
    // Start on trigger: external input (ch3) and channel 0 timeout (ch2)
    for (c = 0; c < 2; c++) begin
      n = (c == 0) ? 3 : 2;
      wr(ca(n, timer_pkg::CH_LOAD_SUB), 32'd5);
      wr(ca(n, timer_pkg::CH_CTRL_SUB), c_en | c_start |
         (c == 0 ? 32'h3 << timer_pkg::CC_SEL_LSB : c_src));
      wait_pulse(n, 30, seen, n);
      n = (c == 0) ? 3 : 2;
      chk("waits for trigger", 32'(seen), 32'h0);
      if (c == 0) begin
        @(posedge sys_clk_i);
        ext_trig_i <= 4'h8;
      end else begin
        wr(ca(0, timer_pkg::CH_LOAD_SUB), 32'd3);
        wr(ca(0, timer_pkg::CH_CTRL_SUB), c_en);
      end
      wait_pulse(n, 30, seen, n);
      chk("starts on trigger", 32'(seen), 32'h1);
      wr(ca((c == 0) ? 3 : 2, timer_pkg::CH_CTRL_SUB), 32'h0);
      wr(ca(0, timer_pkg::CH_CTRL_SUB), 32'h0);
    end
    $display("test start trigger done");
    // Reload on trigger: edges every ten cycles keep a 31 cycle count alive
    @(posedge sys_clk_i);
    ext_trig_i <= 4'h0;
    wr(ca(3, timer_pkg::CH_LOAD_SUB), 32'd30);
    wr(ca(3, timer_pkg::CH_CTRL_SUB),
       c_en | c_rel | (32'h3 << timer_pkg::CC_SEL_LSB));
    w = 32'h0;
    repeat (6) begin
      ext_trig_i <= 4'h8;
      wait_pulse(3, 5, seen, n);
      w = w | 32'(seen);
      ext_trig_i <= 4'h0;
      wait_pulse(3, 5, seen, n);
      w = w | 32'(seen);
    end
    chk("reloaded", w, 32'h0);
    wait_pulse(3, 40, seen, n);
    chk("expires unreloaded", 32'(seen), 32'h1);
    $display("test reload done");
    // Soft reset keeps module control, clears enables, periods, flags and channels
    wr(ien, 32'hf);
    wr(ca(1, timer_pkg::CH_LOAD_SUB), 32'h55);
    wr(timer_pkg::SW_RESET_OFF, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    rd(mcr, v);
    chk("module ctrl kept", v, m_en);
    rd(ien, v);
    chk("int enable cleared", v, 32'h0);
    rd(ca(1, timer_pkg::CH_LOAD_SUB), v);
    chk("load cleared", v, 32'h0);
    rd(sts, v);
    chk("status cleared", v, 32'h0);
    chk("irq after reset", 32'(irq_o), 32'h0);
    wait_pulse(3, 40, seen, n);
    chk("channel stopped", 32'(seen), 32'h0);
    $display("test soft reset done");
    end_sim();
  end
endmodule
